// ### hdl/dtg_decoder.sv
// Tone pair decoder with early steering, guard-time and code latch
`timescale 1ns/1ps
`default_nettype none
`include "dtg_params.svh"
module dtg_decoder #(
   parameter int unsigned CLK_HZ = `DTG_CLK_HZ
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Limited band signals from the filters
   input wire logic low_band_in,
   input wire logic high_band_in,
   // Steering pin: threshold comparator in, guard-time drive out
   input wire logic steer_in,
   output logic guard_time_out,
   output logic guard_time_oe,
   // Detector results
   output logic early_steer_out,
   output logic delayed_steer,
   output logic [3:0] rx_code
);
   import dtg_pkg::*;

   localparam int SETTLE_N = `DTG_SETTLE_CYC;

   // ----------------------------------------
   // Pair to code mapping
   // ----------------------------------------
   function automatic logic [3:0] encode(input logic [1:0] row, input logic [1:0] col);
      logic [3:0] c;
      c = 4'h0;
      case ({row, col})
         4'h0: c = 4'h1;
         4'h1: c = 4'h2;
         4'h2: c = 4'h3;
         4'h3: c = 4'hd;
         4'h4: c = 4'h4;
         4'h5: c = 4'h5;
         4'h6: c = 4'h6;
         4'h7: c = 4'he;
         4'h8: c = 4'h7;
         4'h9: c = 4'h8;
         4'ha: c = 4'h9;
         4'hb: c = 4'hf;
         4'hc: c = 4'hb;
         4'hd: c = 4'ha;
         4'he: c = 4'hc;
         4'hf: c = 4'h0;
         default: c = 4'h0;
      endcase
      return c;
   endfunction : encode

   typedef struct packed {
      logic [1:0] lo_sync;
      logic [1:0] hi_sync;
      logic [1:0] steer_sync;
      dtg_steer_e state;
      logic [3:0] settle;
      logic [3:0] pend;
      logic [3:0] code;
      logic dstr;
      logic early;
      logic guard;
      logic guard_oe;
   } dtg_dec_s;

   dtg_dec_s s_q, s_d;
   dtg_tone_s lo_tone, hi_tone;
   logic steer_s;

   // ----------------------------------------
   // Band measurement
   // ----------------------------------------
   dtg_band_meas #(
      .CLK_HZ(CLK_HZ),
      .F0(`DTG_ROW0_HZ),
      .F1(`DTG_ROW1_HZ),
      .F2(`DTG_ROW2_HZ),
      .F3(`DTG_ROW3_HZ),
      .AVG(`DTG_AVG_PERIODS)
   ) u_low (
      .clk(clk),
      .srst(srst),
      .band(s_q.lo_sync[1]),
      .tone(lo_tone)
   );

   dtg_band_meas #(
      .CLK_HZ(CLK_HZ),
      .F0(`DTG_COL0_HZ),
      .F1(`DTG_COL1_HZ),
      .F2(`DTG_COL2_HZ),
      .F3(`DTG_COL3_HZ),
      .AVG(`DTG_AVG_PERIODS)
   ) u_high (
      .clk(clk),
      .srst(srst),
      .band(s_q.hi_sync[1]),
      .tone(hi_tone)
   );

   assign steer_s = s_q.steer_sync[1];

   // ----------------------------------------
   // Steering sequence
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      // Pins are asynchronous; only the second stage is used
      s_d.lo_sync = {s_q.lo_sync[0], low_band_in};
      s_d.hi_sync = {s_q.hi_sync[0], high_band_in};
      s_d.steer_sync = {s_q.steer_sync[0], steer_in};
      // Combinational loss drops it on the very next edge, no filtering here
      s_d.early = lo_tone.valid && hi_tone.valid;
      case (s_q.state)
         DTG_FREE: begin
            s_d.dstr = 1'b0;
            if (steer_s && s_q.early) begin
               s_d.pend = encode(lo_tone.idx, hi_tone.idx);
               s_d.settle = 4'(SETTLE_N);
               s_d.state = DTG_SETTLE;
            end
         end
         DTG_SETTLE: begin
            if (!steer_s) begin
               s_d.state = DTG_FREE;
            end else if (s_q.settle <= 4'h1) begin
               // Code and flag move together so a reader never sees a stale code flagged
               s_d.dstr = 1'b1;
               s_d.code = s_q.pend;
               s_d.state = DTG_HELD;
            end else begin
               s_d.settle = s_q.settle - 4'h1;
            end
         end
         DTG_HELD: begin
            if (!steer_s) begin
               s_d.dstr = 1'b0;
               s_d.state = DTG_FREE;
            end
         end
         default: begin
            s_d.state = DTG_FREE;
            s_d.dstr = 1'b0;
         end
      endcase
      // Guard-time: pull high once registered and tone holds, low when tone lost
      s_d.guard = s_d.early && (s_d.state != DTG_FREE);
      // Released only while the RC is charging toward the threshold
      s_d.guard_oe = !(s_d.early && s_d.state == DTG_FREE);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
         s_q.state <= DTG_FREE;
         s_q.code <= `DTG_CODE_RST;
         s_q.guard_oe <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign early_steer_out = s_q.early;
   assign guard_time_out = s_q.guard;
   assign guard_time_oe = s_q.guard_oe;
   assign delayed_steer = s_q.dstr;
   assign rx_code = s_q.code;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_early_rise;
      (lo_tone.valid && hi_tone.valid) |=> early_steer_out;
   endproperty
   a_early_rise: assert property (p_early_rise) else $error("Early steering missed a valid pair");

   property p_early_fall;
      !(lo_tone.valid && hi_tone.valid) |=> !early_steer_out;
   endproperty
   a_early_fall: assert property (p_early_fall) else $error("Early steering held after loss");

   property p_register;
      (s_q.state == DTG_FREE && steer_s && early_steer_out)
         |=> s_q.state == DTG_SETTLE && s_q.pend == encode($past(lo_tone.idx), $past(hi_tone.idx));
   endproperty
   a_register: assert property (p_register) else $error("Pair not registered on steering");

   property p_release;
      !steer_s |=> s_q.state == DTG_FREE && !delayed_steer;
   endproperty
   a_release: assert property (p_release) else $error("Not released with steering low");

   sequence s_enter_settle;
      s_q.state == DTG_FREE ##1 s_q.state == DTG_SETTLE;
   endsequence

   // Five quiet cycles for a settle count of five; this count must follow the settle constant
   sequence s_settle_quiet;
      !delayed_steer [*5];
   endsequence

   property p_settle_load;
      s_enter_settle |-> s_q.settle == 4'(SETTLE_N);
   endproperty
   a_settle_load: assert property (p_settle_load) else $error("Settle count not loaded");

   property p_settle_delay;
      s_enter_settle |-> s_settle_quiet;
   endproperty
   a_settle_delay: assert property (p_settle_delay) else $error("Delayed steering too early");

   property p_dstr_on_time;
      (s_q.state == DTG_SETTLE && steer_s && s_q.settle <= 4'h1) |=> delayed_steer && rx_code == $past(s_q.pend);
   endproperty
   a_dstr_on_time: assert property (p_dstr_on_time) else $error("Delayed steering or code late");

   property p_code_hold;
      $changed(rx_code) |-> $rose(delayed_steer);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("Code changed without steering edge");

   property p_guard_hold;
      (guard_time_out && early_steer_out && steer_s) |=> guard_time_out || !early_steer_out;
   endproperty
   a_guard_hold: assert property (p_guard_hold) else $error("Guard-time dropped while tone held");

   property p_guard_low;
      !early_steer_out |-> !guard_time_out && guard_time_oe;
   endproperty
   a_guard_low: assert property (p_guard_low) else $error("Guard-time not driven low");

endmodule : dtg_decoder
`default_nettype wire

// ### hdl/dtg_params.svh
// Constants of the tone decode and steering block
// How it works
// - Count each band's period and accept only the eight standard tones within tolerance.
// - Map the row/column pair to the 4-bit code; zero is ten, D is zero.
// - Raise early steering once one valid row and one valid column tone coexist.
// - Drop early steering at once on any loss of the two-tone condition.
// - Steering input above threshold registers the current pair and updates the latch.
// - Steering input below threshold frees the block to take a new pair.
// - Guard-time output follows early steering and the steering input level.
// - Average several periods so voice and third tones are rejected, small drift tolerated.
// - After registration keep guard-time high while early steering stays high.
// - After a settling delay raise delayed steering to flag a registered pair.
// - Code latch changes only as delayed steering rises, held until next pair.
`ifndef DTG_PARAMS_SVH
`define DTG_PARAMS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define DTG_CLK_HZ 125000000
`define DTG_CLK_NS 8
`define DTG_SETTLE_NS 40
`define DTG_SETTLE_CYC ((`DTG_SETTLE_NS + `DTG_CLK_NS - 1) / `DTG_CLK_NS)

// ----------------------------------------
// Tone set, Hz
// ----------------------------------------
`define DTG_ROW0_HZ 697
`define DTG_ROW1_HZ 770
`define DTG_ROW2_HZ 852
`define DTG_ROW3_HZ 941
`define DTG_COL0_HZ 1209
`define DTG_COL1_HZ 1336
`define DTG_COL2_HZ 1477
`define DTG_COL3_HZ 1633

// ----------------------------------------
// Detector tuning and reset values
// ----------------------------------------
`define DTG_TOL_PERMIL 15
`define DTG_AVG_PERIODS 4
`define DTG_CNT_W 20
`define DTG_CODE_RST 4'h0

`endif

// ### hdl/dtg_pkg.sv
// Types shared by the tone decode and steering block
package dtg_pkg;

   // ----------------------------------------
   // Steering sequence
   // ----------------------------------------
   typedef enum logic [1:0] {
      DTG_FREE,
      DTG_SETTLE,
      DTG_HELD
   } dtg_steer_e;

   // ----------------------------------------
   // One band's detection result
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      logic [1:0] idx;
   } dtg_tone_s;

endpackage : dtg_pkg

// ### hdl/dtg_band_meas.sv
// Period counter and averaging tone classifier for one band
`timescale 1ns/1ps
`default_nettype none
`include "dtg_params.svh"
module dtg_band_meas #(
   parameter int unsigned CLK_HZ = `DTG_CLK_HZ,
   parameter int unsigned F0 = `DTG_ROW0_HZ,
   parameter int unsigned F1 = `DTG_ROW1_HZ,
   parameter int unsigned F2 = `DTG_ROW2_HZ,
   parameter int unsigned F3 = `DTG_ROW3_HZ,
   parameter int unsigned AVG = `DTG_AVG_PERIODS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Synchronised limiter output
   input wire logic band,
   // Detection result
   output dtg_pkg::dtg_tone_s tone
);
   import dtg_pkg::*;

   localparam int CW = `DTG_CNT_W;
   localparam int unsigned NOM [4] = '{CLK_HZ / F0, CLK_HZ / F1, CLK_HZ / F2, CLK_HZ / F3};
   localparam int unsigned TOL = `DTG_TOL_PERMIL;
   localparam int unsigned LONGEST = NOM[0] + NOM[0] * TOL / 1000;
   localparam logic [CW-1:0] LIMIT = CW'(LONGEST + 1);

   // ----------------------------------------
   // Period classifier
   // ----------------------------------------
   function automatic logic [2:0] classify(input logic [CW-1:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 4; i++) begin
         if (32'(p) >= NOM[i] - NOM[i] * TOL / 1000 && 32'(p) <= NOM[i] + NOM[i] * TOL / 1000) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction : classify

   typedef struct packed {
      logic prev;
      logic [CW-1:0] cnt;
      logic [1:0] last;
      logic [3:0] match;
      dtg_tone_s tone;
   } dtg_meas_s;

   dtg_meas_s s_q, s_d;
   logic [2:0] cls;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      cls = classify(s_q.cnt);
      s_d.prev = band;
      if (s_q.cnt < LIMIT) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
      if (band && !s_q.prev) begin
         s_d.cnt = CW'(1);
         if (!cls[2]) begin
            s_d.match = 4'h0;
            s_d.tone.valid = 1'b0;
         end else if (cls[1:0] == s_q.last && s_q.match != 4'h0) begin
            // Several matching periods in a row: one lucky period of speech is not enough
            if (s_q.match < 4'(AVG)) begin
               s_d.match = s_q.match + 4'h1;
            end
            s_d.tone.valid = (s_q.match + 4'h1 >= 4'(AVG));
         end else begin
            s_d.last = cls[1:0];
            s_d.match = 4'h1;
            s_d.tone.valid = 1'b0;
         end
         s_d.tone.idx = cls[1:0];
      end else if (s_q.cnt >= LIMIT) begin
         // Tone gone: no edge within the longest period
         s_d.match = 4'h0;
         s_d.tone.valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tone = s_q.tone;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_bad_period;
      (band && !s_q.prev && !cls[2]) |=> !tone.valid;
   endproperty
   a_bad_period: assert property (p_bad_period) else $error("Off-standard period kept tone valid");

   property p_avg_needed;
      $rose(tone.valid) |-> $past(s_q.match) >= 4'(AVG - 1) && $past(cls[2]);
   endproperty
   a_avg_needed: assert property (p_avg_needed) else $error("Tone valid without averaging");

endmodule : dtg_band_meas
`default_nettype wire

// ### verif/dtg_tone_rc_model.sv
// Band limiter and steering RC network model facing the tone decoder
`timescale 1ns/1ps
`default_nettype none
module dtg_tone_rc_model #(
   parameter int unsigned CLK_HZ = 625000,
   parameter int unsigned GTP_CYC = 200
) (
   // Clock
   input wire logic clk,
   // Tone frequencies in Hz, zero means silent
   input wire logic [11:0] row_hz,
   input wire logic [11:0] col_hz,
   // Steering pin drive and early steering from the block
   input wire logic guard_time_out,
   input wire logic guard_time_oe,
   input wire logic early_steer_out,
   // Limiter outputs and threshold comparator result
   output logic low_band,
   output logic high_band,
   output logic steer_in
);
   logic [15:0] ph_lo;
   logic [15:0] ph_hi;
   logic [15:0] rc;
   function automatic logic [15:0] per(input logic [11:0] f);
      per = (f == 12'h0) ? 16'h0 : 16'(CLK_HZ / f);
   endfunction : per
   initial begin
      ph_lo = 16'h0;
      ph_hi = 16'h0;
      rc = 16'h0;
      low_band = 1'b0;
      high_band = 1'b0;
      steer_in = 1'b0;
   end
   // Square waves of a whole number of clock periods; silent bands sit low
   always @(posedge clk) begin
      ph_lo <= (ph_lo + 16'h1 >= per(row_hz)) ? 16'h0 : ph_lo + 16'h1;
      ph_hi <= (ph_hi + 16'h1 >= per(col_hz)) ? 16'h0 : ph_hi + 16'h1;
      low_band <= #1 (ph_lo < per(row_hz) / 2);
      high_band <= #1 (ph_hi < per(col_hz) / 2);
   end
   // Capacitor charges only while the pin is released and early steering is high;
   // a driven low empties it at once, which is faster than a real RC
   always @(posedge clk) begin
      if (guard_time_oe) begin
         rc <= guard_time_out ? rc : 16'h0;
      end else if (early_steer_out && rc != 16'hffff) begin
         rc <= rc + 16'h1;
      end
      steer_in <= #1 guard_time_oe ? guard_time_out : (rc >= 16'(GTP_CYC));
   end
endmodule : dtg_tone_rc_model
`default_nettype wire

// ### verif/test_dtmf_tone_decode_steering.sv
// Self-checking testbench of the tone decode and steering block
`timescale 1ns/1ps
`default_nettype none
module test_dtmf_tone_decode_steering;
   localparam int unsigned SIM_HZ = 625000;
   localparam logic [11:0] row_f [4] = '{12'h2b9, 12'h302, 12'h354, 12'h3ad};
   localparam logic [11:0] col_f [4] = '{12'h4b9, 12'h538, 12'h5c5, 12'h661};
   logic clk;
   logic srst;
   logic [11:0] row_hz;
   logic [11:0] col_hz;
   logic low_band;
   logic high_band;
   logic steer_in;
   logic guard_time_out;
   logic guard_time_oe;
   logic early_steer_out;
   logic delayed_steer;
   logic [3:0] rx_code;
   int err_total = 0;
   int num_checks = 0;

   dtg_decoder #(.CLK_HZ(SIM_HZ)) i_dtg_decoder (.clk(clk), .srst(srst), .low_band_in(low_band),
      .high_band_in(high_band), .steer_in(steer_in), .guard_time_out(guard_time_out),
      .guard_time_oe(guard_time_oe), .early_steer_out(early_steer_out), .delayed_steer(delayed_steer),
      .rx_code(rx_code));
   // Guard time must outlast the band timeout, else a short burst still reaches the threshold
   dtg_tone_rc_model #(.CLK_HZ(SIM_HZ), .GTP_CYC(800)) i_dtg_tone_rc_model (.clk(clk), .row_hz(row_hz),
      .col_hz(col_hz), .guard_time_out(guard_time_out), .guard_time_oe(guard_time_oe),
      .early_steer_out(early_steer_out), .low_band(low_band), .high_band(high_band), .steer_in(steer_in));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         err_total++;
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : tick

   function automatic logic pick(input int sel);
      pick = (sel == 0) ? early_steer_out : delayed_steer;
   endfunction : pick

   // Bounded wait for early steering (0) or delayed steering (1) to reach a level
   task automatic wait_sig(input int sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while (pick(sel) !== lvl && n < lim) begin
         tick(1);
         n++;
      end
      if (n >= lim) begin
         $display("MISMATCH wait %0d expected %b seen %b", sel, lvl, pick(sel));
         err_total++;
         conclude();
      end
   endtask : wait_sig

   function automatic logic [3:0] code_of(input int r, input int c);
      if (r == 3) code_of = (c == 0) ? 4'hb : (c == 1) ? 4'ha : (c == 2) ? 4'hc : 4'h0;
      else if (c == 3) code_of = 4'(4'hd + r);
      else code_of = 4'(3 * r + c + 1);
   endfunction : code_of

   task automatic t_reset();
      check("early", {3'h0, early_steer_out}, 4'h0);
      check("delayed", {3'h0, delayed_steer}, 4'h0);
      check("guard", {2'h0, guard_time_out, guard_time_oe}, 4'h1);
      check("rx_code", rx_code, 4'h0);
   endtask : t_reset

   // Every pair in turn; the row stays while only the column comes and goes
   task automatic t_digits();
      for (int r = 0; r < 4; r++) begin
         row_hz = row_f[r];
         for (int c = 0; c < 4; c++) begin
            col_hz = col_f[c];
            wait_sig(0, 1'b1, 8000);
            check("oe_free", {3'h0, guard_time_oe}, 4'h0);
            wait_sig(1, 1'b1, 2000);
            check("rx_code", rx_code, code_of(r, c));
            check("guard_hold", {2'h0, guard_time_out, guard_time_oe}, 4'h3);
            col_hz = 12'h0;
            wait_sig(0, 1'b0, 1200);
            wait_sig(1, 1'b0, 20);
            check("guard_low", {3'h0, guard_time_out}, 4'h0);
            check("rx_hold", rx_code, code_of(r, c));
         end
      end
   endtask : t_digits

   // Pair too short for the RC guard time must leave the latch alone
   task automatic t_short();
      col_hz = col_f[0];
      wait_sig(0, 1'b1, 4000);
      tick(50);
      col_hz = 12'h0;
      wait_sig(0, 1'b0, 1200);
      tick(300);
      check("short_delayed", {3'h0, delayed_steer}, 4'h0);
      check("short_code", rx_code, code_of(3, 3));
   endtask : t_short

   // Off-standard column tone between two standard ones is never accepted
   task automatic t_bad();
      int hits;
      hits = 0;
      col_hz = 12'h514;
      for (int i = 0; i < 4000; i++) begin
         tick(1);
         if (early_steer_out !== 1'b0) hits++;
      end
      check("bad_tone", {3'h0, hits != 0}, 4'h0);
      col_hz = 12'h0;
   endtask : t_bad

   initial begin
      srst = 1'b1;
      row_hz = 12'h0;
      col_hz = 12'h0;
      tick(12);
      srst = 1'b0;
      tick(1);
      t_reset();
      t_digits();
      t_short();
      t_bad();
      conclude();
   end
endmodule : test_dtmf_tone_decode_steering
`default_nettype wire
